// file: hw/serial_port_flow_control.sv
// Serial port with open/close configuration, CTS pause and RTS control
// Notes on behaviour
// RL1: Rates 300 to 38,400 bps are chosen at open, and code 0 gives 9,600 bps.
// RL2: The terminal port refuses 38,400 bps and caps at 19,200 bps.
// RL3: Open latches class, line parameters and handshake options until close.
// RL4: With CTS checking, sending pauses while CTS is off and resumes when on.
// RL5: Without CTS checking, CTS is ignored and characters go out freely.
// RL6: With RTS hold, RTS stays on from open until close.
// RL7: Software selects RTS hold when normal reception is wanted.
// RL8: Without RTS hold, RTS is on only while an input or output operation runs.
// RL9: Frame is 7 or 8 bits, none/odd/even parity, 1 or 2 stops; defaults none and 2.
`timescale 1ns/1ps
module serial_port_flow_control #(
  parameter bit TERMINAL_PORT = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cts_in,
  output logic             rts_out,
  output logic             txd_out
);
  serial_tx_if txi ();

  logic [15:0] cfg_r;
  logic [15:0] act_r;
  logic        open_r;
  logic        outop_r;
  logic        inop_r;
  logic [7:0]  txbuf_r;
  logic        txfull_r;
  logic [31:0] prdata_r;
  logic        slverr_r;
  logic [serial_port_pkg::DIV_W-1:0] div_r;
  logic [serial_port_pkg::DIV_W-1:0] div_lim;
  logic        tick;
  logic [3:0]  rate_code;
  serial_port_pkg::tx_state_e st_r;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        cts_ok;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = slverr_r;
  assign mapped  = paddr == serial_port_pkg::OFF_CTRL || paddr == serial_port_pkg::OFF_CFG ||
                   paddr == serial_port_pkg::OFF_TXDATA || paddr == serial_port_pkg::OFF_STATUS;

  // Config staging register; takes effect only at open
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_r <= serial_port_pkg::CFG_RESET;
    end else if (wr && paddr == serial_port_pkg::OFF_CFG) begin
      cfg_r <= pwdata[15:0];
    end
  end

  // Open/close and operation flags
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      open_r  <= 1'b0;
      outop_r <= 1'b0;
      inop_r  <= 1'b0;
      act_r   <= serial_port_pkg::CFG_RESET;
    end else if (wr && paddr == serial_port_pkg::OFF_CTRL) begin
      if (pwdata[serial_port_pkg::CTRL_OPEN] && !open_r) begin
        act_r <= cfg_r; // RL3
        if (TERMINAL_PORT && cfg_r[3:0] == serial_port_pkg::RATE_38400) begin
          act_r[3:0] <= serial_port_pkg::RATE_19200; // RL2
        end
      end
      open_r  <= pwdata[serial_port_pkg::CTRL_OPEN];
      outop_r <= pwdata[serial_port_pkg::CTRL_OUTOP] && pwdata[serial_port_pkg::CTRL_OPEN];
      inop_r  <= pwdata[serial_port_pkg::CTRL_INOP] && pwdata[serial_port_pkg::CTRL_OPEN];
    end
  end

  // Read data and error answer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_r <= 32'h0;
      slverr_r <= 1'b0;
    end else begin
      slverr_r <= 1'b0;
      if (psel && !penable) begin
        slverr_r <= !mapped;
        unique case (paddr)
          serial_port_pkg::OFF_CTRL:   prdata_r <= {29'h0, inop_r, outop_r, open_r};
          serial_port_pkg::OFF_CFG:    prdata_r <= {16'h0, cfg_r};
          serial_port_pkg::OFF_STATUS: prdata_r <= {26'h0, act_r[3:0], txfull_r, rts_out};
          default:                     prdata_r <= 32'h0;
        endcase
      end
    end
  end

  // Rate decode; 38,400 clamps to 19,200 on the terminal port
  always_comb begin
    rate_code = act_r[serial_port_pkg::CFG_RATE_LSB +: 4];
    unique case (rate_code)
      serial_port_pkg::RATE_300:   div_lim = 20'(serial_port_pkg::CLK_HZ / 300 - 1);
      serial_port_pkg::RATE_600:   div_lim = 20'(serial_port_pkg::CLK_HZ / 600 - 1);
      serial_port_pkg::RATE_1200:  div_lim = 20'(serial_port_pkg::CLK_HZ / 1200 - 1);
      serial_port_pkg::RATE_2400:  div_lim = 20'(serial_port_pkg::CLK_HZ / 2400 - 1);
      serial_port_pkg::RATE_4800:  div_lim = 20'(serial_port_pkg::CLK_HZ / 4800 - 1);
      serial_port_pkg::RATE_19200: div_lim =
        20'(serial_port_pkg::CLK_HZ / serial_port_pkg::BPS_19200 - 1);
      serial_port_pkg::RATE_38400: div_lim = TERMINAL_PORT ? // RL2
        20'(serial_port_pkg::CLK_HZ / serial_port_pkg::BPS_19200 - 1) :
        20'(serial_port_pkg::CLK_HZ / serial_port_pkg::BPS_38400 - 1); // RL1
      default: div_lim = 20'(serial_port_pkg::CLK_HZ / serial_port_pkg::BPS_9600 - 1); // RL1
    endcase
  end

  // Bit-rate enable divider
  // Keeps running after close until a character in flight has ended, or the shifter hangs
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_r <= '0;
    end else if ((!open_r && txi.ready) || div_r >= div_lim) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 20'h1;
    end
  end
  assign tick = (open_r || !txi.ready) && div_r >= div_lim;

  // One-character holding register filled by software
  // Writes while full are dropped; software polls the full flag
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      txbuf_r  <= 8'h0;
      txfull_r <= 1'b0;
    end else if (!open_r) begin
      txfull_r <= 1'b0;
    end else if (txi.valid && txi.ready) begin
      txfull_r <= 1'b0;
    end else if (wr && paddr == serial_port_pkg::OFF_TXDATA && !txfull_r) begin
      txbuf_r  <= pwdata[7:0];
      txfull_r <= 1'b1;
    end
  end

  // CTS only gates character starts during an output operation
  assign cts_ok = !act_r[serial_port_pkg::CFG_CTS_CHK] || cts_in; // RL4 RL5

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= serial_port_pkg::TX_IDLE;
    end else begin
      unique case (st_r)
        serial_port_pkg::TX_IDLE:
          if (open_r && outop_r && txfull_r) begin
            st_r <= cts_ok ? serial_port_pkg::TX_SHIFT : serial_port_pkg::TX_WAIT_CTS;
          end
        serial_port_pkg::TX_WAIT_CTS:
          if (!open_r) begin
            st_r <= serial_port_pkg::TX_IDLE;
          end else if (cts_ok) begin
            st_r <= serial_port_pkg::TX_SHIFT; // RL4
          end
        serial_port_pkg::TX_SHIFT:
          if (txi.valid && txi.ready) begin
            st_r <= serial_port_pkg::TX_IDLE;
          end
        default: st_r <= serial_port_pkg::TX_IDLE;
      endcase
    end
  end

  assign txi.data     = txbuf_r;
  assign txi.valid    = st_r == serial_port_pkg::TX_SHIFT && txfull_r;
  assign txi.len8     = act_r[serial_port_pkg::CFG_LEN8]; // RL9
  assign txi.parity   = act_r[serial_port_pkg::CFG_PAR_LSB +: 2];
  assign txi.stop2    = act_r[serial_port_pkg::CFG_STOP2];
  assign txi.bit_tick = tick;

  serial_tx_shifter u_shift (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .tx        (txi),
    .txd_out   (txd_out)
  );

  // RTS: held while open, or pulsed around operations
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rts_out <= 1'b0;
    end else if (act_r[serial_port_pkg::CFG_RTS_HOLD]) begin
      rts_out <= open_r; // RL6 RL7
    end else begin
      rts_out <= open_r && (outop_r || inop_r); // RL8
    end
  end
endmodule

// file: hw/serial_port_pkg.sv
// Package with constants, register map and enumerations for the serial port
package serial_port_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_CFG     = 8'h04;
  localparam logic [7:0]  OFF_TXDATA  = 8'h08;
  localparam logic [7:0]  OFF_STATUS  = 8'h0c;
  // Rate codes; code 0 and 6 both mean 9,600 bps
  localparam logic [3:0]  RATE_DEF    = 4'h0;
  localparam logic [3:0]  RATE_300    = 4'h1;
  localparam logic [3:0]  RATE_600    = 4'h2;
  localparam logic [3:0]  RATE_1200   = 4'h3;
  localparam logic [3:0]  RATE_2400   = 4'h4;
  localparam logic [3:0]  RATE_4800   = 4'h5;
  localparam logic [3:0]  RATE_9600   = 4'h6;
  localparam logic [3:0]  RATE_19200  = 4'h7;
  localparam logic [3:0]  RATE_38400  = 4'h8;
  localparam int unsigned BPS_300     = 300;
  localparam int unsigned BPS_9600    = 9600;
  localparam int unsigned BPS_19200   = 19200;
  localparam int unsigned BPS_38400   = 38400;
  // CFG field positions
  localparam int unsigned CFG_RATE_LSB = 0;
  localparam int unsigned CFG_LEN8     = 4;
  localparam int unsigned CFG_PAR_LSB  = 5;
  localparam int unsigned CFG_STOP2    = 7;
  localparam int unsigned CFG_CTS_CHK  = 8;
  localparam int unsigned CFG_RTS_HOLD = 9;
  localparam int unsigned CFG_CLASS_LSB = 12;
  localparam logic [15:0] CFG_RESET    = 16'h0090;
  // CTRL bits
  localparam int unsigned CTRL_OPEN    = 0;
  localparam int unsigned CTRL_OUTOP   = 1;
  localparam int unsigned CTRL_INOP    = 2;
  localparam logic [1:0]  PAR_NONE     = 2'h0;
  localparam logic [1:0]  PAR_ODD      = 2'h1;
  localparam logic [1:0]  PAR_EVEN     = 2'h2;
  localparam logic [3:0]  CLASS_GENERAL_COMM_DEVICE = 4'h6;
  localparam int unsigned DIV_W        = 20;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT_CTS, TX_SHIFT} tx_state_e;
endpackage

// file: hw/serial_tx_if.sv
// Interface carrying frame settings and character handshake to the shifter
`timescale 1ns/1ps
interface serial_tx_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  logic       len8;
  logic [1:0] parity;
  logic       stop2;
  logic       bit_tick;
  modport ctl (output data, output valid, input ready, output len8, output parity,
               output stop2, output bit_tick);
  modport shf (input data, input valid, output ready, input len8, input parity,
               input stop2, input bit_tick);
endinterface

// file: hw/serial_tx_shifter.sv
// Character shifter: start, data, parity and stop bits at the bit-rate enable
`timescale 1ns/1ps
module serial_tx_shifter (
  input  wire logic   clk_in,
  input  wire logic   arst_n_in,
  serial_tx_if.shf    tx,
  output logic        txd_out
);
  logic [11:0] sh_r;
  logic [3:0]  cnt_r;
  logic        busy_r;
  logic        par;
  logic [3:0]  nbits;

  assign tx.ready = !busy_r;
  always_comb begin
    par = tx.len8 ? ^tx.data : ^tx.data[6:0];
    if (tx.parity == serial_port_pkg::PAR_ODD) begin
      par = ~par;
    end
    nbits = 4'(1 + (tx.len8 ? 8 : 7) + (tx.parity != serial_port_pkg::PAR_NONE ? 1 : 0)
                + (tx.stop2 ? 2 : 1));
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_r  <= 1'b0;
      sh_r    <= 12'hfff;
      cnt_r   <= 4'h0;
      txd_out <= 1'b1;
    end else if (!busy_r) begin
      txd_out <= 1'b1;
      if (tx.valid) begin
        busy_r <= 1'b1;
        cnt_r  <= nbits;
        // RL9
        if (tx.len8) begin
          sh_r <= (tx.parity != serial_port_pkg::PAR_NONE) ? {2'b11, par, tx.data, 1'b0}
                                                          : {3'b111, tx.data, 1'b0};
        end else begin
          sh_r <= (tx.parity != serial_port_pkg::PAR_NONE) ? {3'b111, par, tx.data[6:0], 1'b0}
                                                          : {4'b1111, tx.data[6:0], 1'b0};
        end
      end
    end else if (tx.bit_tick) begin
      if (cnt_r == 4'h0) begin
        busy_r <= 1'b0;
      end else begin
        txd_out <= sh_r[0];
        sh_r    <= {1'b1, sh_r[11:1]};
        cnt_r   <= cnt_r - 4'h1;
      end
    end
  end
endmodule

// file: verif/serial_port_flow_control_chk.sv
// Port-level assertions for the serial port with flow control
`timescale 1ns/1ps
module serial_port_flow_control_chk #(
  parameter int unsigned IDLE_MIN = 28700
) (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cts_in,
  input wire logic        rts_out,
  input wire logic        txd_out
);
  // Idle bound exceeds the longest run of ones inside a 38,400 bps frame
  logic [2:0]  ctrl_r;
  logic [1:0]  stage_r;
  logic [1:0]  act_r;
  int unsigned hi_r;
  wire         wr   = psel && penable && pwrite && pready;
  wire         idle = hi_r >= IDLE_MIN;
  wire         bad  = paddr > 8'h0c || paddr[1:0] != 2'h0;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r  <= 3'h0;
      stage_r <= 2'h0;
      act_r   <= 2'h0;
    end else if (wr && paddr == serial_port_pkg::OFF_CTRL) begin
      ctrl_r <= pwdata[2:0];
      if (pwdata[0] && !ctrl_r[0]) act_r <= stage_r;
    end else if (wr && paddr == serial_port_pkg::OFF_CFG) begin
      stage_r <= pwdata[9:8];
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) hi_r <= 0;
    else if (!txd_out) hi_r <= 0;
    else if (!idle) hi_r <= hi_r + 1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (psel && penable && bad |-> pslverr) else $error("no err");
  a_err_mapped: assert property (psel && penable && !bad |-> !pslverr) else $error("err");
  a_status_rts: assert property (psel && penable && !pwrite && paddr == 8'h0c
    && $stable(rts_out) |-> prdata[0] == rts_out) else $error("status rts wrong");
  a_rts_hold: assert property (act_r[1] && ctrl_r[0] && $past(ctrl_r[0]) |-> rts_out)
    else $error("rts dropped while open");
  a_rts_pulse: assert property (!act_r[1] && $stable(ctrl_r)
    |-> rts_out == (ctrl_r[0] && ctrl_r[2:1] != 2'h0)) else $error("rts pulse wrong");
  a_rts_closed: assert property (!ctrl_r[0] && $stable(ctrl_r) |-> !rts_out)
    else $error("rts on while closed");
  a_cts_pause: assert property (!cts_in [*4] ##0 (act_r[0] && ctrl_r[0] && idle)
    |=> txd_out) else $error("sent while cts off");
  a_closed_quiet: assert property (!ctrl_r[0] && !$past(ctrl_r[0]) && idle |=> txd_out)
    else $error("sent while closed");
  c_pause: cover property (act_r[0] && ctrl_r[0] && !cts_in && idle);
  c_hold: cover property (act_r[1] && rts_out);
  c_refused: cover property (pslverr);
endmodule
bind serial_port_flow_control serial_port_flow_control_chk chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cts_in(cts_in), .rts_out(rts_out), .txd_out(txd_out)
);

// file: verif/serial_peer_model.sv
// Model of the external serial device: CTS source and frame sampler
`timescale 1ns/1ps
module serial_peer_model #(
  parameter int unsigned BIT_CLKS = 2604
) (
  input  wire logic   clk_in,
  input  wire logic   txd_in,
  input  wire logic   busy_in,
  output logic        cts_out,
  output logic [11:0] frame_out,
  output logic [7:0]  count_out
);
  // A full receive buffer withdraws CTS as a steady level
  assign cts_out = !busy_in;
  // Samples mid-bit: start, then eleven slots; idle slots read high
  initial begin
    frame_out = 12'hfff;
    count_out = 8'h0;
    forever begin
      @(negedge txd_in);
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (int i = 0; i < 12; i++) begin
        frame_out[i] <= txd_in;
        if (i < 11) repeat (BIT_CLKS) @(posedge clk_in);
      end
      count_out <= count_out + 8'h1;
    end
  end
endmodule

// file: verif/serial_port_flow_control_bench.sv
// Self-checking bench for the serial port with flow control
`timescale 1ns/1ps
module serial_port_flow_control_bench;
  localparam logic [7:0] A_CTRL = serial_port_pkg::OFF_CTRL;
  localparam logic [7:0] A_CFG  = serial_port_pkg::OFF_CFG;
  localparam logic [7:0] A_TX   = serial_port_pkg::OFF_TXDATA;
  localparam logic [7:0] A_ST   = serial_port_pkg::OFF_STATUS;
  logic        clk_in, arst_n_in, psel, penable, pwrite, busy;
  logic        pready, pslverr, cts_in, rts_out, txd_out, err;
  logic [7:0]  paddr, count;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] frame;
  logic [2:0]  ops [5] = '{3'h1, 3'h3, 3'h5, 3'h1, 3'h6};
  int          fails = 0;
  int          checks = 0;
  serial_port_flow_control #(.TERMINAL_PORT(1'b0)) dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cts_in(cts_in), .rts_out(rts_out), .txd_out(txd_out)
  );
  serial_peer_model peer (
    .clk_in(clk_in), .txd_in(txd_out), .busy_in(busy), .cts_out(cts_in),
    .frame_out(frame), .count_out(count)
  );
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen high; no wait-state count assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  task automatic frame_chk(input logic [11:0] exp);
    logic [7:0] c0;
    int         n;
    c0 = count;
    for (n = 0; n < 40000 && count === c0; n++) @(posedge clk_in);
    if (n == 40000) begin
      fails++;
      report_and_stop();
    end
    chk({20'h0, frame}, {20'h0, exp});
  endtask
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (99000) @(posedge clk_in);
    fails++;
    report_and_stop();
  end
  initial begin
    arst_n_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    busy = 1'b0;
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rchk(A_CFG, 32'hffff, 32'h0090);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int c = 1; c <= 8; c++) begin
      apb(1'b1, A_CFG, 32'(c));
      apb(1'b1, A_CTRL, 32'h1);
      rchk(A_ST, 32'h3c, 32'(c) << 2);
      apb(1'b1, A_CTRL, 32'h0);
    end
    $display("test rates done");
    // Hold RTS so the far side may send at any time while open
    apb(1'b1, A_CFG, 32'h0208);
    apb(1'b1, A_CTRL, 32'h1);
    rchk(A_ST, 32'h1, 32'h1);
    apb(1'b1, A_CTRL, 32'h7);
    apb(1'b1, A_CTRL, 32'h1);
    rchk(A_ST, 32'h1, 32'h1);
    apb(1'b1, A_CTRL, 32'h0);
    rchk(A_ST, 32'h1, 32'h0);
    apb(1'b1, A_CFG, 32'h0008);
    foreach (ops[i]) begin
      apb(1'b1, A_CTRL, {29'h0, ops[i]});
      rchk(A_ST, 32'h1, {31'h0, ops[i][0] && ops[i][2:1] != 2'h0});
    end
    $display("test rts done");
    busy <= 1'b1;
    apb(1'b1, A_CFG, 32'h01d8);
    apb(1'b1, A_CTRL, 32'h3);
    apb(1'b1, A_TX, 32'h00a5);
    repeat (29000) @(posedge clk_in);
    chk({24'h0, count}, 32'h0);
    rchk(A_ST, 32'h2, 32'h2);
    busy <= 1'b0;
    frame_chk({2'b11, 1'b0, 8'ha5, 1'b0});
    $display("test cts pause done");
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_CFG, 32'h0028);
    busy <= 1'b1;
    apb(1'b1, A_CTRL, 32'h3);
    apb(1'b1, A_TX, 32'h0035);
    apb(1'b1, A_CFG, 32'h0001);
    rchk(A_ST, 32'h3c, 32'h20);
    frame_chk({3'b111, 1'b1, 7'h35, 1'b0});
    $display("test cts ignored done");
    report_and_stop();
  end
endmodule
